// >>> bench/kmsd_pipe_model.sv
// Pipeline-side model that issues address lookups and exception events
`timescale 1ns/1ps
module kmsd_pipe_model (
	input  wire logic          pclk,
	output kmsd_pkg::kmsd_req_t req,
	output logic               exc_detect,
	output logic               exc_return
);
	// Idle lines start low
	initial
	begin
		req = '0;
		exc_detect = 1'b0;
		exc_return = 1'b0;
	end
	// Addresses come fully formed, never from an overflowing base plus offset
	// One-cycle lookup; stale address inverted so a held value is never trusted
	task automatic lookup(input logic [63:0] va);
		req <= '{valid: 1'b1, vaddr: va};
		@(posedge pclk);
		req <= '{valid: 1'b0, vaddr: ~va};
	endtask
	// One-cycle exception detect or return pulse
	task automatic event_pulse(input logic det, input logic ret);
		exc_detect <= det;
		exc_return <= ret;
		@(posedge pclk);
		exc_detect <= 1'b0;
		exc_return <= 1'b0;
	endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench: APB register access and segment decode lookups
`timescale 1ns/1ps
module testbench;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                exc_detect;
	logic                exc_return;
	kmsd_pkg::kmsd_req_t req;
	kmsd_pkg::kmsd_res_t res;
	logic                kernel_priv;
	logic                wide_refill_sel;
	int                  err_total;
	int                  n_compared;
	int                  cyc;
	logic [31:0]         rd;
	logic                er;

	kmsd_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .exc_detect(exc_detect), .exc_return(exc_return), .req(req),
		.res(res), .kernel_priv(kernel_priv), .wide_refill_sel(wide_refill_sel));
	kmsd_pipe_model model_u (.pclk(pclk), .req(req), .exc_detect(exc_detect),
		.exc_return(exc_return));

	// 125 MHz clock
	always #4 pclk = ~pclk;

	// Hang guard, far above the hundred or so cycles the tests need
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		if (n >= 50)
			chk("pready", 1'b0, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Lookup with expected result; seg F skips segment, faults skip cached and paddr
	task automatic look(input logic [63:0] va, input logic kn, input logic [3:0] sg,
		input logic mp, input logic ca, input logic ae, input logic [31:0] pa);
		model_u.lookup(va);
		#1;
		chk("res.valid", res.valid, 1'b1);
		chk("res.kernel", res.kernel, kn);
		chk("res.addr_err", res.addr_err, ae);
		if (sg !== 4'hF)
			chk("res.seg", res.seg, sg);
		chk("res.mapped", res.mapped, mp);
		if (mp === 1'b1)
			chk("res.tag", res.tag, 8'h5A);
		if (mp === 1'b0 && ae === 1'b0)
		begin
			chk("res.cached", res.cached, ca);
			chk("res.paddr", res.paddr, pa);
		end
		@(posedge pclk);
	endtask

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		n_compared = 0;
		cyc = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values and register access
		chk("kernel_priv", kernel_priv, 1'b1);
		apb(1'b0, kmsd_pkg::OFS_MODE, 32'h0);
		chk("mode", rd, 32'h68);
		apb(1'b0, 8'h14, 32'h0);
		chk("pslverr", er, 1'b1);
		apb(1'b1, kmsd_pkg::OFS_TAG, 32'h5A);
		apb(1'b0, kmsd_pkg::OFS_TAG, 32'h0);
		chk("tag", rd, 32'h5A);
		look(64'h1234_5000, 1'b1, 4'hF, 1'b0, 1'b0, 1'b0, 32'h1234_5000);
		$display("test reset_regs done");
		// Privilege from mode, exception and return
		apb(1'b1, kmsd_pkg::OFS_MODE, 32'h62);
		chk("kernel_priv", kernel_priv, 1'b0);
		look(64'hFFFF_FFFF_E000_0000, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 32'h0);
		apb(1'b1, kmsd_pkg::OFS_MODE, 32'h61);
		chk("kernel_priv", kernel_priv, 1'b0);
		model_u.event_pulse(1'b1, 1'b0);
		@(posedge pclk);
		chk("kernel_priv", kernel_priv, 1'b1);
		apb(1'b0, kmsd_pkg::OFS_MODE, 32'h0);
		chk("mode", rd, 32'h65);
		model_u.event_pulse(1'b0, 1'b1);
		@(posedge pclk);
		chk("kernel_priv", kernel_priv, 1'b0);
		$display("test privilege done");
		// 32-bit kernel segments
		apb(1'b1, kmsd_pkg::OFS_MODE, 32'h60);
		chk("wide_refill_sel", wide_refill_sel, 1'b0);
		look(64'h1234_5000, 1'b1, 4'h1, 1'b1, 1'b0, 1'b0, 32'h0);
		look(64'hFFFF_FFFF_9000_0000, 1'b1, 4'h2, 1'b0, 1'b1, 1'b0, 32'h1000_0000);
		look(64'hFFFF_FFFF_B000_0004, 1'b1, 4'h3, 1'b0, 1'b0, 1'b0, 32'h1000_0004);
		look(64'hFFFF_FFFF_C000_0000, 1'b1, 4'h4, 1'b1, 1'b0, 1'b0, 32'h0);
		look(64'hFFFF_FFFF_DFFF_FFFF, 1'b1, 4'h4, 1'b1, 1'b0, 1'b0, 32'h0);
		look(64'hFFFF_FFFF_E000_0000, 1'b1, 4'h5, 1'b1, 1'b0, 1'b0, 32'h0);
		apb(1'b1, kmsd_pkg::OFS_MODE, 32'h40);
		look(64'hFFFF_FFFF_9FFF_FFFC, 1'b1, 4'h2, 1'b0, 1'b0, 1'b0, 32'h1FFF_FFFC);
		$display("test segments32 done");
		// 64-bit kernel segments
		apb(1'b1, kmsd_pkg::OFS_MODE, 32'h70);
		chk("wide_refill_sel", wide_refill_sel, 1'b1);
		look(64'h0000_00FF_0000_0000, 1'b1, 4'h6, 1'b1, 1'b0, 1'b0, 32'h0);
		chk("res.wide_refill", res.wide_refill, 1'b1);
		look(64'h4000_0012_0000_0000, 1'b1, 4'h7, 1'b1, 1'b0, 1'b0, 32'h0);
		look(64'h9000_0000_1234_5678, 1'b1, 4'h8, 1'b0, 1'b0, 1'b0, 32'h1234_5678);
		look(64'h8800_0000_0000_0040, 1'b1, 4'h8, 1'b0, 1'b1, 1'b0, 32'h40);
		look(64'h8000_0001_0000_0000, 1'b1, 4'hF, 1'b0, 1'b0, 1'b1, 32'h0);
		look(64'hC000_00FF_7FFF_FFFF, 1'b1, 4'h9, 1'b1, 1'b0, 1'b0, 32'h0);
		look(64'hC000_00FF_8000_0000, 1'b1, 4'hE, 1'b0, 1'b0, 1'b1, 32'h0);
		look(64'h0000_0100_0000_0000, 1'b1, 4'hE, 1'b0, 1'b0, 1'b1, 32'h0);
		apb(1'b0, kmsd_pkg::OFS_ERR_HI, 32'h0);
		chk("err_hi", rd, 32'h0000_0100);
		apb(1'b0, kmsd_pkg::OFS_STAT, 32'h0);
		chk("status", rd, 32'h7B);
		look(64'hFFFF_FFFF_8000_0010, 1'b1, 4'hA, 1'b0, 1'b1, 1'b0, 32'h10);
		look(64'hFFFF_FFFF_A000_0020, 1'b1, 4'hB, 1'b0, 1'b0, 1'b0, 32'h20);
		look(64'hFFFF_FFFF_C000_0000, 1'b1, 4'hC, 1'b1, 1'b0, 1'b0, 32'h0);
		look(64'hFFFF_FFFF_E000_0000, 1'b1, 4'hD, 1'b1, 1'b0, 1'b0, 32'h0);
		apb(1'b1, kmsd_pkg::OFS_MODE, 32'h78);
		look(64'h0000_0000_1234_5000, 1'b1, 4'hF, 1'b0, 1'b0, 1'b0, 32'h1234_5000);
		$display("test segments64 done");
		give_verdict();
	end
endmodule

// >>> core/kmsd_decoder.sv
// Kernel privilege and segment decoder with its APB register file
//
// What this block does
// RQ1: Kernel when mode 00, or EXCEPTION_LEVEL_BIT, or ERROR_LEVEL_BIT
// RQ2: Wide bit picks 64-bit map and refill
// RQ3: Exception enters kernel; return restores prior mode
// RQ4: 32-bit A31 clear: tagged mapped user segment
// RQ5: Error level makes user region unmapped, uncached
// RQ6: Top bits 100: unmapped, minus base, attribute cached
// RQ7: Top bits 101: unmapped, minus base, uncached
// RQ8: Top bits 110: tagged mapped supervisor segment
// RQ9: Top bits 111: tagged mapped kernel segment
// RQ10: Wide region 00: tagged mapped user segment
// RQ11: Wide region 01: tagged mapped supervisor segment
// RQ12: Wide region 10: physical window, 58:32 checked
// RQ13: Wide region 11: mapped kernel up to end
// RQ14: Bits 61:31 all ones choose compatibility windows
// RQ15: Compat cached window follows attribute field
// RQ16: Compat uncached window is unmapped, uncached
// RQ17: Compat supervisor and kernel windows mapped
// RQ18: 32-bit addresses not checked for sign extension
// RQ19: Software avoids signed 32-bit address overflow
// RQ20: Address space tag is eight bits
// RQ21: Undecoded wide addresses raise address error
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module kmsd_decoder (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                exc_detect,
	input  wire logic                exc_return,
	input  wire kmsd_pkg::kmsd_req_t req,
	output kmsd_pkg::kmsd_res_t      res,
	output logic                     kernel_priv,
	output logic                     wide_refill_sel
);

	kmsd_pkg::kmsd_mode_t             mode_q;
	kmsd_pkg::kmsd_mode_t             mode_d;
	logic [kmsd_pkg::TAG_W-1:0]       tag_q;
	kmsd_pkg::kmsd_res_t              res_d;
	kmsd_pkg::kmsd_res_t              res_q;
	kmsd_pkg::kmsd_stat_t             stat_q;
	logic [63:0]                      errva_q;
	logic                             kernel_q;
	logic                             wide_q;
	logic [31:0]                      prdata_q;
	logic [31:0]                      rd_mux;
	logic                             hit;
	logic                             pready_q;
	logic                             pslverr_q;
	logic                             setup;
	logic                             wr_acc;
	logic                             wr_mode;
	logic                             wr_tag;
	logic [63:0]                      va;
	logic                             kern_now;

	// Kernel privilege from the three mode conditions
	function automatic logic is_kernel(input kmsd_pkg::kmsd_mode_t m);
		is_kernel = (m.privilege_mode_field == kmsd_pkg::PRIV_KERNEL)
			|| m.exception_level_bit || m.error_level_bit; // [RQ1]
	endfunction

	// Upper half of a 32-bit kernel map; shared by compat windows
	function automatic kmsd_pkg::kmsd_res_t dec_top(
		input logic [31:0]          a,
		input kmsd_pkg::kmsd_mode_t m,
		input logic [7:0]           t,
		input logic                 compat
	);
		kmsd_pkg::kmsd_res_t r;
		r = '0;
		unique case (a[31:29])
			kmsd_pkg::TOP_CACHED:
			begin
				r.seg    = compat ? kmsd_pkg::SEG_C_CACHED : kmsd_pkg::SEG_K_CACHED;
				r.paddr  = a - kmsd_pkg::BASE_CACHED; // [RQ6] [RQ15]
				r.cached = m.unmapped_cache_attribute_field != kmsd_pkg::ATTR_UNCACHED;
			end
			kmsd_pkg::TOP_UNCACHED:
			begin
				r.seg    = compat ? kmsd_pkg::SEG_C_UNCACHED : kmsd_pkg::SEG_K_UNCACHED;
				r.paddr  = a - kmsd_pkg::BASE_UNCACHED; // [RQ7] [RQ16]
				r.cached = 1'b0;
			end
			kmsd_pkg::TOP_SUPER:
			begin
				r.seg    = compat ? kmsd_pkg::SEG_C_SUPER : kmsd_pkg::SEG_K_SUPER;
				r.mapped = 1'b1; // [RQ8] [RQ17]
				r.tag    = t;
			end
			kmsd_pkg::TOP_MAPPED:
			begin
				r.seg    = compat ? kmsd_pkg::SEG_C_MAPPED : kmsd_pkg::SEG_K_MAPPED;
				r.mapped = 1'b1; // [RQ9] [RQ17]
				r.tag    = t;
			end
			default:
			begin
				r.seg      = kmsd_pkg::SEG_BAD;
				r.addr_err = 1'b1;
			end
		endcase
		dec_top = r;
	endfunction

	// APB phase decode; a zero-wait slave
	assign setup   = psel && !penable;
	assign wr_acc  = psel && penable && pready_q && pwrite;
	assign wr_mode = wr_acc && (paddr == kmsd_pkg::OFS_MODE);
	assign wr_tag  = wr_acc && (paddr == kmsd_pkg::OFS_TAG);

	// Read mux; unmapped offsets read zero and flag an error
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		hit    = 1'b1;
		unique case (paddr)
			kmsd_pkg::OFS_MODE:   rd_mux = {24'h00_0000, mode_q};
			kmsd_pkg::OFS_TAG:    rd_mux = {24'h00_0000, tag_q};
			kmsd_pkg::OFS_STAT:   rd_mux = {25'h000_0000, stat_q};
			kmsd_pkg::OFS_ERR_LO: rd_mux = errva_q[31:0];
			kmsd_pkg::OFS_ERR_HI: rd_mux = errva_q[63:32];
			default:              hit    = 1'b0;
		endcase
	end

	// Answer phase: ready follows every setup cycle by one edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= setup;
			pslverr_q <= setup && !hit;
			prdata_q  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Mode next value; hardware events win over a software write
	always_comb
	begin
		mode_d = mode_q;
		if (wr_mode)
			mode_d = kmsd_pkg::kmsd_mode_t'(pwdata[7:0]);
		if (exc_detect)
			mode_d.exception_level_bit = 1'b1; // [RQ3]
		else if (exc_return)
		begin
			// Error level is unwound first, as the return would
			if (mode_q.error_level_bit)
				mode_d.error_level_bit = 1'b0; // [RQ3]
			else
				mode_d.exception_level_bit = 1'b0; // [RQ3]
		end
	end

	// Mode register and derived privilege outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q   <= '{kmsd_pkg::K0_RST, kmsd_pkg::KX_RST, kmsd_pkg::ERL_RST,
				kmsd_pkg::EXL_RST, kmsd_pkg::PRIV_RST};
			kernel_q <= 1'b1;
			wide_q   <= 1'b0;
		end
		else
		begin
			mode_q   <= mode_d;
			kernel_q <= is_kernel(mode_d); // [RQ1]
			wide_q   <= is_kernel(mode_d) && mode_d.kernel_wide_addressing_bit; // [RQ2]
		end
	end

	// Address space tag register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tag_q <= kmsd_pkg::TAG_RST;
		else if (wr_tag)
			tag_q <= pwdata[kmsd_pkg::TAG_W-1:0]; // [RQ20]
	end

	assign va       = req.vaddr;
	assign kern_now = is_kernel(mode_q);

	// Segment decode of the presented virtual address
	always_comb
	begin
		res_d             = '0;
		res_d.seg         = kmsd_pkg::SEG_NONE;
		if (!kern_now)
			res_d.seg = kmsd_pkg::SEG_NONE;
		else if (!mode_q.kernel_wide_addressing_bit)
		begin
			// Bits 63:32 are trusted to mirror bit 31 here
			if (!va[31]) // [RQ18]
			begin
				res_d.seg = kmsd_pkg::SEG_K_USER;
				if (mode_q.error_level_bit)
					res_d.paddr = va[31:0]; // [RQ5]
				else
				begin
					res_d.mapped = 1'b1; // [RQ4]
					res_d.tag    = tag_q;
				end
			end
			else
				res_d = dec_top(va[31:0], mode_q, tag_q, 1'b0);
		end
		else
		begin
			unique case (va[63:62])
				kmsd_pkg::RGN_USER:
				begin
					res_d.seg = kmsd_pkg::SEG_X_USER;
					if (mode_q.error_level_bit && (va[61:31] == '0))
						res_d.paddr = va[31:0]; // [RQ5]
					else if (va[61:40] != '0)
					begin
						res_d.seg      = kmsd_pkg::SEG_BAD;
						res_d.addr_err = 1'b1; // [RQ21]
					end
					else
					begin
						res_d.mapped = 1'b1; // [RQ10]
						res_d.tag    = tag_q;
					end
				end
				kmsd_pkg::RGN_SUPER:
				begin
					res_d.seg = kmsd_pkg::SEG_X_SUPER;
					if (va[61:40] != '0)
					begin
						res_d.seg      = kmsd_pkg::SEG_BAD;
						res_d.addr_err = 1'b1; // [RQ21]
					end
					else
					begin
						res_d.mapped = 1'b1; // [RQ11]
						res_d.tag    = tag_q;
					end
				end
				kmsd_pkg::RGN_PHYS:
				begin
					res_d.seg = kmsd_pkg::SEG_X_PHYS;
					if (va[58:32] != '0)
						res_d.addr_err = 1'b1; // [RQ12]
					else
					begin
						// Bits 61:59 carry the window's cache attribute
						res_d.paddr  = va[31:0]; // [RQ12]
						res_d.cached = va[61:59] != kmsd_pkg::ATTR_UNCACHED;
					end
				end
				kmsd_pkg::RGN_KERNEL:
				begin
					if (&va[61:31])
						res_d = dec_top(va[31:0], mode_q, tag_q, 1'b1); // [RQ14]
					else if (va <= kmsd_pkg::XMAPPED_END)
					begin
						res_d.seg    = kmsd_pkg::SEG_X_MAPPED;
						res_d.mapped = 1'b1; // [RQ13]
						res_d.tag    = tag_q;
					end
					else
					begin
						res_d.seg      = kmsd_pkg::SEG_BAD;
						res_d.addr_err = 1'b1; // [RQ21]
					end
				end
			endcase
		end
		res_d.valid       = req.valid;
		res_d.kernel      = kern_now;
		res_d.wide_refill = kern_now && mode_q.kernel_wide_addressing_bit; // [RQ2]
	end

	// Result register; a one-cycle answer to each valid request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			res_q <= '0;
		else if (req.valid)
			res_q <= res_d;
		else
			res_q.valid <= 1'b0;
	end

	// Status and faulting address for software inspection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_q  <= '{1'b0, kmsd_pkg::SEG_NONE, 1'b0, 1'b1};
			errva_q <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			stat_q.kernel <= is_kernel(mode_d);
			stat_q.wide   <= is_kernel(mode_d) && mode_d.kernel_wide_addressing_bit;
			if (req.valid)
			begin
				stat_q.last_seg <= res_d.seg;
				stat_q.last_err <= res_d.addr_err;
			end
			// Only a faulting reference overwrites the held address
			if (req.valid && res_d.addr_err)
				errva_q <= va;
		end
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign res             = res_q;
	assign kernel_priv     = kernel_q;
	assign wide_refill_sel = wide_q;

	// Privilege output matches the mode conditions
	AST_KERNEL_COND: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
		kernel_priv == ((mode_q.privilege_mode_field == kmsd_pkg::PRIV_KERNEL)
			|| mode_q.exception_level_bit || mode_q.error_level_bit))
		else $error("kernel privilege does not match mode");

	// An exception always yields kernel privilege next cycle
	AST_EXC_ENTER: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
		exc_detect |=> kernel_priv && mode_q.exception_level_bit)
		else $error("exception did not enter kernel");

	// Exception level holds until a return or a write
	AST_EXC_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
		(mode_q.exception_level_bit && !exc_return && !wr_mode) |=> mode_q.exception_level_bit)
		else $error("exception level dropped early");

	// Refill route follows the wide bit in kernel
	AST_WIDE: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
		(req.valid && kern_now) |=> res.wide_refill == $past(mode_q.kernel_wide_addressing_bit))
		else $error("refill route wrong");

	// User region mapped and tagged outside error level
	AST_USER_MAP: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
		(req.valid && kern_now && !mode_q.kernel_wide_addressing_bit && !va[31]
			&& !mode_q.error_level_bit) |=> res.mapped && res.tag == $past(tag_q))
		else $error("user segment not mapped");

	// Error level turns the user region into direct space
	AST_ERL_DIRECT: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
		(req.valid && mode_q.error_level_bit && !mode_q.kernel_wide_addressing_bit && !va[31])
		|=> !res.mapped && !res.cached && res.paddr == $past(va[31:0]))
		else $error("error level user region wrong");

	// Cached direct segment subtracts its base
	AST_CACHED_PA: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
		(req.valid && kern_now && !mode_q.kernel_wide_addressing_bit
			&& va[31:29] == kmsd_pkg::TOP_CACHED)
		|=> res.paddr == $past(va[31:0]) - kmsd_pkg::BASE_CACHED && !res.mapped)
		else $error("cached direct address wrong");

	// Uncached direct segment never caches
	AST_UNCACHED_PA: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
		(req.valid && kern_now && !mode_q.kernel_wide_addressing_bit
			&& va[31:29] == kmsd_pkg::TOP_UNCACHED)
		|=> res.paddr == $past(va[31:0]) - kmsd_pkg::BASE_UNCACHED && !res.cached)
		else $error("uncached direct address wrong");

	// Physical window checks bits 58:32
	AST_PHYS_ERR: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
		(req.valid && kern_now && mode_q.kernel_wide_addressing_bit
			&& va[63:62] == kmsd_pkg::RGN_PHYS && va[58:32] != '0) |=> res.addr_err)
		else $error("physical window error missed");

	// Beyond the mapped kernel end and outside compat: error
	AST_XK_END: assert property (@(posedge pclk) disable iff (!presetn) // [RQ21]
		(req.valid && kern_now && mode_q.kernel_wide_addressing_bit && !(&va[61:31])
			&& va > kmsd_pkg::XMAPPED_END) |=> res.addr_err && !res.mapped)
		else $error("undecoded wide address accepted");

	// All-ones middle bits land in a compat window next cycle
	AST_COMPAT: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
		(req.valid && kern_now && mode_q.kernel_wide_addressing_bit
			&& va[63:62] == kmsd_pkg::RGN_KERNEL && (&va[61:31]))
		|=> res.valid && !res.addr_err && res.seg inside {kmsd_pkg::SEG_C_CACHED,
			kmsd_pkg::SEG_C_UNCACHED, kmsd_pkg::SEG_C_SUPER, kmsd_pkg::SEG_C_MAPPED})
		else $error("compat window not selected");

endmodule

// >>> core/kmsd_pkg.sv
// Constants, types and register map of the kernel segment decoder
package kmsd_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_TAG    = 8'h04;
	localparam logic [7:0] OFS_STAT   = 8'h08;
	localparam logic [7:0] OFS_ERR_LO = 8'h0C;
	localparam logic [7:0] OFS_ERR_HI = 8'h10;

	// Widths
	localparam int unsigned TAG_W = 8;
	localparam int unsigned PA_W  = 32;

	// Reset values of the mode register fields and the tag register
	localparam logic [1:0] PRIV_RST  = 2'h0;
	localparam logic       EXL_RST   = 1'h0;
	localparam logic       ERL_RST   = 1'h1;
	localparam logic       KX_RST    = 1'h0;
	localparam logic [2:0] K0_RST    = 3'h3;
	localparam logic [7:0] TAG_RST   = 8'h00;

	// Field codes
	localparam logic [1:0] PRIV_KERNEL   = 2'h0;
	localparam logic [2:0] ATTR_UNCACHED = 3'h2;
	localparam logic [2:0] TOP_CACHED    = 3'h4;
	localparam logic [2:0] TOP_UNCACHED  = 3'h5;
	localparam logic [2:0] TOP_SUPER     = 3'h6;
	localparam logic [2:0] TOP_MAPPED    = 3'h7;
	localparam logic [1:0] RGN_USER      = 2'h0;
	localparam logic [1:0] RGN_SUPER     = 2'h1;
	localparam logic [1:0] RGN_PHYS      = 2'h2;
	localparam logic [1:0] RGN_KERNEL    = 2'h3;

	// Address constants
	localparam logic [31:0] BASE_CACHED   = 32'h8000_0000;
	localparam logic [31:0] BASE_UNCACHED = 32'hA000_0000;
	localparam logic [63:0] XMAPPED_END   = 64'hC000_00FF_7FFF_FFFF;

	typedef enum logic [3:0] {
		SEG_NONE, SEG_K_USER, SEG_K_CACHED, SEG_K_UNCACHED, SEG_K_SUPER, SEG_K_MAPPED,
		SEG_X_USER, SEG_X_SUPER, SEG_X_PHYS, SEG_X_MAPPED,
		SEG_C_CACHED, SEG_C_UNCACHED, SEG_C_SUPER, SEG_C_MAPPED, SEG_BAD
	} kmsd_seg_t;

	// Mode register layout, bit 7 downward
	typedef struct packed {
		logic [2:0] unmapped_cache_attribute_field;
		logic       kernel_wide_addressing_bit;
		logic       error_level_bit;
		logic       exception_level_bit;
		logic [1:0] privilege_mode_field;
	} kmsd_mode_t;

	typedef struct packed {
		logic        last_err;
		kmsd_seg_t   last_seg;
		logic        wide;
		logic        kernel;
	} kmsd_stat_t;

	typedef struct packed {
		logic        valid;
		logic [63:0] vaddr;
	} kmsd_req_t;

	typedef struct packed {
		logic             valid;
		logic             kernel;
		logic             wide_refill;
		logic             mapped;
		logic             cached;
		logic             addr_err;
		kmsd_seg_t        seg;
		logic [TAG_W-1:0] tag;
		logic [PA_W-1:0]  paddr;
	} kmsd_res_t;

endpackage
